//--- rtl/ppp_buf_if.sv
// page buffer access bundle between port logic and buffer memory
`timescale 1ns/1ps
`default_nettype none
interface ppp_buf_if;
  logic        wr_en;
  logic [6:0]  wr_idx;
  logic [15:0] wr_data;
  logic [6:0]  rd_idx;
  logic [15:0] rd_data;
  modport ctrl (output wr_en, output wr_idx, output wr_data,
                output rd_idx, input rd_data);
  modport mem  (input wr_en, input wr_idx, input wr_data,
                input rd_idx, output rd_data);
endinterface : ppp_buf_if
`default_nettype wire

//--- rtl/ppp_page_buf.sv
// page buffer memory, 128 words of 16 bits, registered read
`timescale 1ns/1ps
`default_nettype none
module ppp_page_buf
  import ppp_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  ppp_buf_if.mem    bus
);
  logic [15:0] mem_q [BUF_DEPTH];
  logic [15:0] rd_q;

  // write port
  always_ff @(posedge clk) begin
    if (bus.wr_en) begin
      mem_q[bus.wr_idx] <= bus.wr_data;
    end
  end

  // read data leave through a register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 16'h0000;
    end else begin
      rd_q <= mem_q[bus.rd_idx];
    end
  end

  assign bus.rd_data = rd_q;
endmodule : ppp_page_buf
`default_nettype wire

//--- rtl/ppp_pin_sync.sv
// two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ps
`default_nettype none
module ppp_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);
  logic [W-1:0] stage1_q;
  logic [W-1:0] stage2_q;

  // first stage is read by the second stage only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= pin_in;
      stage2_q <= stage1_q;
    end
  end

  assign pin_sync = stage2_q;
endmodule : ppp_pin_sync
`default_nettype wire

//--- rtl/ppp_pkg.sv
// shared constants and types of the parallel programming port
package ppp_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 10;
  localparam int T_ENTRY_HOLD_NS  = 100;
  localparam int T_PAGE_PROG_NS   = 4500000;
  localparam int T_EE_PROG_NS     = 9000000;
  localparam int T_CHIP_ERASE_NS  = 9000000;
  localparam int T_FUSE_PROG_NS   = 4500000;
  // least time rounds up to whole cycles
  localparam int ENTRY_HOLD_CYC   =
    (T_ENTRY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] ENTRY_HOLD_LAST = 4'(ENTRY_HOLD_CYC - 1);
  localparam int WAIT_W           = 24;

  // ---------------------------------------------------------------
  // strobe actions and command bytes
  // ---------------------------------------------------------------
  localparam logic [1:0] XA_ADDR  = 2'h0;
  localparam logic [1:0] XA_DATA  = 2'h1;
  localparam logic [1:0] XA_CMD   = 2'h2;
  localparam logic [3:0] ENTRY_PATTERN = 4'h0;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE    = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK    = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH   = 8'h10;
  localparam logic [7:0] CMD_WR_EE      = 8'h11;
  localparam logic [7:0] CMD_RD_SIG     = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE    = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH   = 8'h02;
  localparam logic [7:0] CMD_RD_EE      = 8'h03;
  localparam logic [7:0] CMD_NOP        = 8'h00;

  // ---------------------------------------------------------------
  // memory geometry
  // ---------------------------------------------------------------
  localparam int FLASH_WORD_W = 7;
  localparam int BUF_DEPTH    = 128;
  localparam logic [6:0] FLASH_LAST_WORD = 7'h7F;
  localparam logic [6:0] EE_LAST_BYTE    = 7'h07;
  localparam int PRESERVE_EE_BIT = 3;

  // ---------------------------------------------------------------
  // nonvolatile defaults and identity bytes (identity values arbitrary)
  // ---------------------------------------------------------------
  localparam logic [7:0] FUSE_LOW_RESET  = 8'h62;
  localparam logic [7:0] FUSE_HIGH_RESET = 8'h99;
  localparam logic [7:0] FUSE_EXT_RESET  = 8'hFF;
  localparam logic [7:0] LOCK_RESET      = 8'hFF;
  localparam logic [7:0] SIG_BYTE0       = 8'hA5;
  localparam logic [7:0] SIG_BYTE1       = 8'h5A;
  localparam logic [7:0] SIG_BYTE2       = 8'h3C;
  localparam logic [7:0] CAL_BYTE        = 8'h80;
  localparam logic [7:0] UNMAPPED_BYTE   = 8'hFF;

  // ---------------------------------------------------------------
  // synchronised pin vector positions
  // ---------------------------------------------------------------
  localparam int PIN_W = 17;
  localparam int P_HV = 0, P_XTAL = 1, P_PAGE_LOAD_STROBE = 2, P_WRN = 3, P_OEN = 4;
  localparam int P_BS1 = 5, P_BS2 = 6, P_XA0 = 7, P_XA1 = 8, P_DAT = 9;

  typedef enum logic [1:0] {
    MD_OFF  = 2'b00,
    MD_HOLD = 2'b01,
    MD_ON   = 2'b10,
    MD_FAIL = 2'b11
  } ppp_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_STREAM   = 3'b001,
    ST_WAIT     = 3'b010,
    ST_ERASE_FL = 3'b011,
    ST_ERASE_EE = 3'b100,
    ST_LOCK_CLR = 3'b101
  } ppp_state_t;

endpackage : ppp_pkg

//--- rtl/ppp_top.sv
// parallel programming port: strobe decode, page buffer, program sequencer
//
// Contract
// - ready/busy low while an operation runs
// - data bus driven only while output enable low
// - first byte select picks low or high byte
// - second byte select picks second high byte
// - load strobe action set by two action bits
// - decode the five write command bytes
// - decode the four read command bytes
// - flash: 512 pages of 128 words
// - eeprom: 8-byte pages, address bits 11:3 page
// - command and address kept across operations
// - chip erase clears flash, locks, eeprom only while high fuse bit 3 is set, not fuses
// - locks cleared only after flash fully erased
// - write strobe starts chip erase, busy low
// - page load latches data word into buffer
// - upper low-address bits join page select
// - write strobe programs buffered page, busy low
// - command 00 ends page programming
`timescale 1ns/1ps
`default_nettype none
module ppp_top
  import ppp_pkg::*;
#(
  parameter logic [WAIT_W-1:0] PAGE_PROG_CYC =
    WAIT_W'(T_PAGE_PROG_NS / CLK_PERIOD_NS),
  parameter logic [WAIT_W-1:0] EE_PROG_CYC =
    WAIT_W'(T_EE_PROG_NS / CLK_PERIOD_NS),
  parameter logic [WAIT_W-1:0] ERASE_CYC =
    WAIT_W'(T_CHIP_ERASE_NS / CLK_PERIOD_NS),
  parameter logic [WAIT_W-1:0] FUSE_CYC =
    WAIT_W'(T_FUSE_PROG_NS / CLK_PERIOD_NS)
) (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        PROG_VOLTAGE_IN,
  input  wire logic        LOAD_STROBE_CLOCK_IN,
  input  wire logic        PAGE_LOAD_STROBE,
  input  wire logic        WRITE_STROBE_N,
  input  wire logic        OUTPUT_ENABLE_N,
  input  wire logic        BYTE_SELECT_LO_HI,
  input  wire logic        BYTE_SELECT_SECOND_HIGH,
  input  wire logic        ACTION_SELECT_BIT0,
  input  wire logic        ACTION_SELECT_BIT1,
  input  wire logic [7:0]  DATA_IN,
  output logic      [7:0]  DATA_OUT,
  output logic             DATA_OE,
  output logic             READY_BUSY_OUT,
  output logic             PROG_MODE_OUT,
  output logic             ENTRY_FAIL_OUT,
  output logic      [15:0] ARR_ADDR,
  output logic      [15:0] ARR_WDATA,
  output logic             ARR_FLASH_WE,
  output logic             ARR_EE_WE,
  output logic             ARR_FLASH_ERASE,
  output logic             ARR_EE_ERASE,
  input  wire logic [15:0] ARR_FLASH_RDATA,
  input  wire logic [7:0]  ARR_EE_RDATA,
  output logic      [7:0]  FUSE_LOW_OUT,
  output logic      [7:0]  FUSE_HIGH_OUT,
  output logic      [7:0]  FUSE_EXT_OUT,
  output logic      [7:0]  LOCK_BITS_OUT
);

  // ---------------------------------------------------------------
  // pin synchronisation and edge detection
  // ---------------------------------------------------------------
  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] pins_raw;
  logic [3:0]       prev_q;     // hv, load strobe, page load, write
  logic [3:0]       prev_d;

  assign pins_raw = {DATA_IN, ACTION_SELECT_BIT1, ACTION_SELECT_BIT0,
                     BYTE_SELECT_SECOND_HIGH, BYTE_SELECT_LO_HI,
                     OUTPUT_ENABLE_N, WRITE_STROBE_N, PAGE_LOAD_STROBE,
                     LOAD_STROBE_CLOCK_IN, PROG_VOLTAGE_IN};

  ppp_pin_sync #(.W(PIN_W)) u_sync (
    .clk      (CLK),
    .rst_n    (RSTN),
    .pin_in   (pins_raw),
    .pin_sync (pins)
  );

  logic       hv;
  logic       xtal;
  logic       page_load_strobe;
  logic       wr_n;
  logic       oe_n;
  logic       bs1;
  logic       bs2;
  logic [1:0] xa;
  logic [7:0] din;
  logic       hv_rise;
  logic       xtal_rise;
  logic       page_load_strobe_rise;
  logic       wr_fall;
  logic [3:0] entry_pat;

  // decoded views of the synchronised pins
  assign hv         = pins[P_HV];
  assign xtal       = pins[P_XTAL];
  assign page_load_strobe      = pins[P_PAGE_LOAD_STROBE];
  assign wr_n       = pins[P_WRN];
  assign oe_n       = pins[P_OEN];
  assign bs1        = pins[P_BS1];
  assign bs2        = pins[P_BS2];
  assign xa         = {pins[P_XA1], pins[P_XA0]};
  assign din        = pins[P_DAT +: 8];
  assign prev_d     = {wr_n, page_load_strobe, xtal, hv};
  assign hv_rise    = hv & ~prev_q[0];
  assign xtal_rise  = xtal & ~prev_q[1];
  assign page_load_strobe_rise = page_load_strobe & ~prev_q[2];
  assign wr_fall    = ~wr_n & prev_q[3];
  assign entry_pat  = {page_load_strobe, xa, bs1};

  // ---------------------------------------------------------------
  // page buffer
  // ---------------------------------------------------------------
  ppp_buf_if buf_bus ();

  ppp_page_buf u_buf (
    .clk   (CLK),
    .rst_n (RSTN),
    .bus   (buf_bus.mem)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  ppp_mode_t         mode_q, mode_d;
  ppp_state_t        state_q, state_d;
  logic [3:0]        hold_q, hold_d;
  logic [7:0]        cmd_q, cmd_d;
  logic [7:0]        addr_lo_q, addr_lo_d;
  logic [7:0]        addr_hi_q, addr_hi_d;
  logic [7:0]        data_lo_q, data_lo_d;
  logic [7:0]        data_hi_q, data_hi_d;
  logic [15:0]       base_q, base_d;
  logic [6:0]        idx_q, idx_d;
  logic [6:0]        last_q, last_d;
  logic [6:0]        wr_idx_q, wr_idx_d;
  logic              strm_v_q, strm_v_d;
  logic              strm_ee_q, strm_ee_d;
  logic [WAIT_W-1:0] wait_q, wait_d;
  logic [7:0]        fuse_lo_q, fuse_lo_d;
  logic [7:0]        fuse_hi_q, fuse_hi_d;
  logic [7:0]        fuse_ex_q, fuse_ex_d;
  logic [7:0]        lock_q, lock_d;
  logic [7:0]        dout_q, dout_d;
  logic              doe_q, doe_d;
  logic              ready_q, ready_d;
  logic [15:0]       aaddr_q, aaddr_d;
  logic [15:0]       awdata_q, awdata_d;
  logic              fl_we_q, fl_we_d;
  logic              ee_we_q, ee_we_d;
  logic              fl_er_q, fl_er_d;
  logic              ee_er_q, ee_er_d;
  logic              buf_wr;
  logic [6:0]        buf_wr_idx;
  logic              in_mode;
  logic              idle;
  logic              mode_on_q, mode_on_d;
  logic              mode_fail_q, mode_fail_d;

  assign in_mode = (mode_q == MD_ON);
  assign idle    = (state_q == ST_IDLE);

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    mode_d    = mode_q;
    state_d   = state_q;
    hold_d    = hold_q;
    cmd_d     = cmd_q;
    addr_lo_d = addr_lo_q;
    addr_hi_d = addr_hi_q;
    data_lo_d = data_lo_q;
    data_hi_d = data_hi_q;
    base_d    = base_q;
    idx_d     = idx_q;
    last_d    = last_q;
    wr_idx_d  = idx_q;
    strm_ee_d = strm_ee_q;
    wait_d    = wait_q;
    fuse_lo_d = fuse_lo_q;
    fuse_hi_d = fuse_hi_q;
    fuse_ex_d = fuse_ex_q;
    lock_d    = lock_q;
    fl_er_d   = 1'b0;
    ee_er_d   = 1'b0;
    buf_wr    = 1'b0;
    buf_wr_idx = addr_lo_q[FLASH_WORD_W-1:0];

    // mode entry: pattern caught at voltage rise, then held stable
    case (mode_q)
      MD_OFF: begin
        if (hv_rise) begin
          if (entry_pat == ENTRY_PATTERN) begin
            mode_d = MD_HOLD;
            hold_d = 4'h0;
          end else begin
            mode_d = MD_FAIL;
          end
        end
      end
      MD_HOLD: begin
        if (!hv) begin
          mode_d = MD_OFF;
        end else if (entry_pat != ENTRY_PATTERN) begin
          mode_d = MD_FAIL;
        end else if (hold_q == ENTRY_HOLD_LAST) begin
          mode_d = MD_ON;
        end else begin
          hold_d = hold_q + 4'h1;
        end
      end
      MD_ON, MD_FAIL: begin
        if (!hv) begin
          mode_d = MD_OFF;
        end
      end
      default: mode_d = MD_OFF;
    endcase

    // load strobe: action bits pick the target register
    if (in_mode && xtal_rise) begin
      case (xa)
        XA_ADDR: begin
          if (bs1) begin
            addr_hi_d = din;
          end else begin
            addr_lo_d = din;
          end
        end
        XA_DATA: begin
          if (bs1) begin
            data_hi_d = din;
          end else begin
            data_lo_d = din;
          end
        end
        XA_CMD: begin
          // command held until replaced; 00 disarms writes
          if (idle) begin
            cmd_d = din;
          end
        end
        default: ;
      endcase
    end

    // page load: latch the assembled word at the current address
    if (in_mode && page_load_strobe_rise) begin
      buf_wr = 1'b1;
      if (cmd_q == CMD_WR_EE) begin
        buf_wr_idx = {4'h0, addr_lo_q[2:0]};
      end
    end

    // write strobe starts the operation chosen by the command
    if (in_mode && idle && wr_fall) begin
      case (cmd_q)
        CMD_CHIP_ERASE: begin
          state_d = ST_ERASE_FL;
          fl_er_d = 1'b1;
          wait_d  = ERASE_CYC;
        end
        CMD_WR_FLASH: begin
          state_d   = ST_STREAM;
          base_d    = {addr_hi_q, addr_lo_q[7], 7'h00};
          idx_d     = 7'h00;
          last_d    = FLASH_LAST_WORD;
          strm_ee_d = 1'b0;
          wait_d    = PAGE_PROG_CYC;
        end
        CMD_WR_EE: begin
          state_d   = ST_STREAM;
          base_d    = {4'h0, addr_hi_q[3:0], addr_lo_q[7:3], 3'h0};
          idx_d     = 7'h00;
          last_d    = EE_LAST_BYTE;
          strm_ee_d = 1'b1;
          wait_d    = EE_PROG_CYC;
        end
        CMD_WR_FUSE: begin
          state_d = ST_WAIT;
          wait_d  = FUSE_CYC;
          if (bs1 && !bs2) begin
            fuse_hi_d = data_lo_q;
          end else if (!bs1 && bs2) begin
            fuse_ex_d = data_lo_q;
          end else begin
            fuse_lo_d = data_lo_q;
          end
        end
        CMD_WR_LOCK: begin
          state_d = ST_WAIT;
          wait_d  = FUSE_CYC;
          lock_d  = lock_q & data_lo_q;             // zero programs a lock
        end
        default: ;
      endcase
    end

    // sequencer
    case (state_q)
      ST_IDLE: ;                // keeps an operation started above
      ST_STREAM: begin
        if (idx_q == last_q) begin
          state_d = ST_WAIT;
        end else begin
          idx_d = idx_q + 7'h01;
        end
      end
      ST_WAIT: begin
        if (wait_q == '0) begin
          state_d = ST_IDLE;
        end else begin
          wait_d = wait_q - WAIT_W'(1);
        end
      end
      ST_ERASE_FL: begin
        if (wait_q != '0) begin
          wait_d = wait_q - WAIT_W'(1);
        end else if (!fuse_hi_q[PRESERVE_EE_BIT]) begin
          state_d = ST_LOCK_CLR;
        end else begin
          state_d = ST_ERASE_EE;
          ee_er_d = 1'b1;
          wait_d  = ERASE_CYC;
        end
      end
      ST_ERASE_EE: begin
        if (wait_q == '0) begin
          state_d = ST_LOCK_CLR;
        end else begin
          wait_d = wait_q - WAIT_W'(1);
        end
      end
      ST_LOCK_CLR: begin
        lock_d  = LOCK_RESET;
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase

    // leaving programming mode abandons any operation
    if (!hv) begin
      state_d = ST_IDLE;
    end
  end

  assign buf_bus.wr_en   = buf_wr;
  assign buf_bus.wr_idx  = buf_wr_idx;
  assign buf_bus.wr_data = {data_hi_q, data_lo_q};
  assign buf_bus.rd_idx  = idx_q;

  // ---------------------------------------------------------------
  // output stage: array writes, read-back and ready
  // ---------------------------------------------------------------
  always_comb begin
    strm_v_d = (state_q == ST_STREAM);
    fl_we_d  = strm_v_q & ~strm_ee_q;
    ee_we_d  = strm_v_q & strm_ee_q;
    awdata_d = strm_ee_q ? {8'h00, buf_bus.rd_data[7:0]}
                         : buf_bus.rd_data;
    aaddr_d  = strm_v_q ? (base_q | {9'h000, wr_idx_q})
                        : {addr_hi_q, addr_lo_q};
    ready_d  = (state_d == ST_IDLE);
    doe_d    = in_mode & ~oe_n;
    mode_on_d   = (mode_d == MD_ON);
    mode_fail_d = (mode_d == MD_FAIL);
    case (cmd_q)
      CMD_RD_SIG: begin
        if (bs1) begin
          dout_d = CAL_BYTE;
        end else begin
          case (addr_lo_q[1:0])
            2'h0:    dout_d = SIG_BYTE0;
            2'h1:    dout_d = SIG_BYTE1;
            2'h2:    dout_d = SIG_BYTE2;
            default: dout_d = UNMAPPED_BYTE;
          endcase
        end
      end
      CMD_RD_FUSE: begin
        case ({bs2, bs1})
          2'b00:   dout_d = fuse_lo_q;
          2'b11:   dout_d = fuse_hi_q;
          2'b10:   dout_d = fuse_ex_q;
          default: dout_d = lock_q;
        endcase
      end
      CMD_RD_FLASH: begin
        dout_d = bs1 ? ARR_FLASH_RDATA[15:8] : ARR_FLASH_RDATA[7:0];
      end
      CMD_RD_EE: dout_d = ARR_EE_RDATA;
      default:   dout_d = UNMAPPED_BYTE;
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      prev_q    <= 4'h0;
      mode_q    <= MD_OFF;
      state_q   <= ST_IDLE;
      hold_q    <= 4'h0;
      cmd_q     <= CMD_NOP;
      addr_lo_q <= 8'h00;
      addr_hi_q <= 8'h00;
      data_lo_q <= 8'h00;
      data_hi_q <= 8'h00;
      base_q    <= 16'h0000;
      idx_q     <= 7'h00;
      last_q    <= 7'h00;
      wr_idx_q  <= 7'h00;
      strm_v_q  <= 1'b0;
      strm_ee_q <= 1'b0;
      wait_q    <= '0;
      fuse_lo_q <= FUSE_LOW_RESET;
      fuse_hi_q <= FUSE_HIGH_RESET;
      fuse_ex_q <= FUSE_EXT_RESET;
      lock_q    <= LOCK_RESET;
      dout_q    <= 8'h00;
      doe_q     <= 1'b0;
      ready_q   <= 1'b1;
      aaddr_q   <= 16'h0000;
      awdata_q  <= 16'h0000;
      fl_we_q   <= 1'b0;
      ee_we_q   <= 1'b0;
      fl_er_q   <= 1'b0;
      ee_er_q   <= 1'b0;
      mode_on_q <= 1'b0;
      mode_fail_q <= 1'b0;
    end else begin
      prev_q    <= prev_d;
      mode_q    <= mode_d;
      state_q   <= state_d;
      hold_q    <= hold_d;
      cmd_q     <= cmd_d;
      addr_lo_q <= addr_lo_d;
      addr_hi_q <= addr_hi_d;
      data_lo_q <= data_lo_d;
      data_hi_q <= data_hi_d;
      base_q    <= base_d;
      idx_q     <= idx_d;
      last_q    <= last_d;
      wr_idx_q  <= wr_idx_d;
      strm_v_q  <= strm_v_d;
      strm_ee_q <= strm_ee_d;
      wait_q    <= wait_d;
      fuse_lo_q <= fuse_lo_d;
      fuse_hi_q <= fuse_hi_d;
      fuse_ex_q <= fuse_ex_d;
      lock_q    <= lock_d;
      dout_q    <= dout_d;
      doe_q     <= doe_d;
      ready_q   <= ready_d;
      aaddr_q   <= aaddr_d;
      awdata_q  <= awdata_d;
      fl_we_q   <= fl_we_d;
      ee_we_q   <= ee_we_d;
      fl_er_q   <= fl_er_d;
      ee_er_q   <= ee_er_d;
      mode_on_q <= mode_on_d;
      mode_fail_q <= mode_fail_d;
    end
  end

  // outputs straight from registers
  assign DATA_OUT        = dout_q;
  assign DATA_OE         = doe_q;
  assign READY_BUSY_OUT  = ready_q;
  assign PROG_MODE_OUT   = mode_on_q;
  assign ENTRY_FAIL_OUT  = mode_fail_q;
  assign ARR_ADDR        = aaddr_q;
  assign ARR_WDATA       = awdata_q;
  assign ARR_FLASH_WE    = fl_we_q;
  assign ARR_EE_WE       = ee_we_q;
  assign ARR_FLASH_ERASE = fl_er_q;
  assign ARR_EE_ERASE    = ee_er_q;
  assign FUSE_LOW_OUT    = fuse_lo_q;
  assign FUSE_HIGH_OUT   = fuse_hi_q;
  assign FUSE_EXT_OUT    = fuse_ex_q;
  assign LOCK_BITS_OUT   = lock_q;

endmodule : ppp_top
`default_nettype wire

//--- tb/ppp_array_model.sv
// memory array model behind the programming port
`timescale 1ns/1ps
`default_nettype none
module ppp_array_model (
  input  wire logic        clk,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdat,
  input  wire logic        fwe,
  input  wire logic        ewe,
  input  wire logic        fer,
  input  wire logic        eer,
  output logic      [15:0] frd,
  output logic      [7:0]  erd
);
  logic [15:0] fl [65536];
  logic [7:0]  ee [4096];
  // flash word writes, eeprom byte writes and whole-array erase, erased cells read all ones
  always @(posedge clk) begin
    if (fwe) fl[addr] <= wdat;
    if (ewe) ee[addr[11:0]] <= wdat[7:0];
    if (fer) foreach (fl[i]) fl[i] <= 16'hFFFF;
    if (eer) foreach (ee[i]) ee[i] <= 8'hFF;
  end
  assign frd = fl[addr];
  assign erd = ee[addr[11:0]];
endmodule : ppp_array_model
`default_nettype wire

//--- tb/ppp_monitor.sv
// concurrent checks on the programming port pins
`timescale 1ns/1ps
`default_nettype none
module ppp_monitor (
  input wire logic        CLK,
  input wire logic        RSTN,
  input wire logic        OUTPUT_ENABLE_N,
  input wire logic        DATA_OE,
  input wire logic        READY_BUSY_OUT,
  input wire logic [15:0] ARR_ADDR,
  input wire logic        ARR_FLASH_WE,
  input wire logic        ARR_EE_WE,
  input wire logic        ARR_FLASH_ERASE,
  input wire logic [7:0]  FUSE_HIGH_OUT,
  input wire logic [7:0]  LOCK_BITS_OUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // a flash page write opens with an unbroken burst of at least 8 word writes
  sequence s_burst;
    ARR_FLASH_WE [*8];
  endsequence
  a_oe_off: assert property (OUTPUT_ENABLE_N |-> ##3 !DATA_OE)
    else $error("bus driven while disabled");
  a_we_busy: assert property ((ARR_FLASH_WE || ARR_EE_WE) |->
    !READY_BUSY_OUT) else $error("write while ready");
  a_erase_busy: assert property (ARR_FLASH_ERASE |->
    !READY_BUSY_OUT) else $error("erase while ready");
  a_page_burst: assert property ($rose(ARR_FLASH_WE) |-> s_burst)
    else $error("page burst broken");
  a_page_base: assert property ($rose(ARR_FLASH_WE) |->
    ARR_ADDR[6:0] == 7'h00) else $error("burst not at page start");
  a_word_step: assert property (ARR_FLASH_WE &&
    $past(ARR_FLASH_WE) |-> ARR_ADDR == $past(ARR_ADDR) + 16'h0001)
    else $error("word step");
  a_lock_late: assert property (ARR_FLASH_ERASE |=>
    $stable(LOCK_BITS_OUT) [*8]) else $error("locks cleared early");
  a_fuse_kept: assert property (ARR_FLASH_ERASE |=>
    $stable(FUSE_HIGH_OUT) [*8]) else $error("fuse changed by erase");
endmodule : ppp_monitor
bind ppp_top ppp_monitor i_ppp_monitor (.CLK, .RSTN, .OUTPUT_ENABLE_N,
  .DATA_OE, .READY_BUSY_OUT, .ARR_ADDR, .ARR_FLASH_WE, .ARR_EE_WE,
  .ARR_FLASH_ERASE, .FUSE_HIGH_OUT, .LOCK_BITS_OUT);
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench of the parallel programming port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ppp_pkg::*;
  logic clk = 1'h0, rstn = 1'h0, hv = 1'h0, xt = 1'h0, pl = 1'h0;
  logic wrn = 1'h1, oen = 1'h1, bs1 = 1'h0, bs2 = 1'h0;
  logic [1:0] xa = 2'h0;
  logic [7:0] din = 8'h00, dout, flo, fhi, fex, lck, erd, ah;
  logic doe, rdy, pm, ef, fwe, ewe, fer, eer;
  logic [15:0] addr, wdat, frd, pg [128];
  logic [31:0] lf = 32'hBE4D;
  int errors = 0, total_checks = 0, cyc = 0;
  always #5 clk = ~clk;
  ppp_top #(.PAGE_PROG_CYC(24'h14), .EE_PROG_CYC(24'h14),
    .ERASE_CYC(24'h14), .FUSE_CYC(24'h14)) i_ppp_top (.CLK(clk),
    .RSTN(rstn), .PROG_VOLTAGE_IN(hv), .LOAD_STROBE_CLOCK_IN(xt),
    .PAGE_LOAD_STROBE(pl), .WRITE_STROBE_N(wrn), .OUTPUT_ENABLE_N(oen),
    .BYTE_SELECT_LO_HI(bs1), .BYTE_SELECT_SECOND_HIGH(bs2),
    .ACTION_SELECT_BIT0(xa[0]), .ACTION_SELECT_BIT1(xa[1]),
    .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe), .READY_BUSY_OUT(rdy),
    .PROG_MODE_OUT(pm), .ENTRY_FAIL_OUT(ef), .ARR_ADDR(addr),
    .ARR_WDATA(wdat), .ARR_FLASH_WE(fwe), .ARR_EE_WE(ewe),
    .ARR_FLASH_ERASE(fer), .ARR_EE_ERASE(eer), .ARR_FLASH_RDATA(frd),
    .ARR_EE_RDATA(erd), .FUSE_LOW_OUT(flo), .FUSE_HIGH_OUT(fhi),
    .FUSE_EXT_OUT(fex), .LOCK_BITS_OUT(lck));
  ppp_array_model i_ppp_array_model (.clk, .addr, .wdat, .fwe, .ewe,
    .fer, .eer, .frd, .erd);
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  // expected signature byte at a low address
  function automatic logic [7:0] sig_of(logic [1:0] a);
    return a == 2'h0 ? SIG_BYTE0 : a == 2'h1 ? SIG_BYTE1 :
      a == 2'h2 ? SIG_BYTE2 : UNMAPPED_BYTE;
  endfunction : sig_of
  task automatic chk(logic [39:0] got, logic [39:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic w(int n);
    repeat (n) @(negedge clk);
  endtask : w
  // load strobe with action, byte select and data set up first
  task automatic ld(logic [1:0] a, logic b, logic [7:0] d);
    xa = a; bs1 = b; din = d;
    w(26); xt = 1'h1; w(26); xt = 1'h0;
  endtask : ld
  // write strobe, then a bounded wait for ready
  task automatic go(logic busy);
    wrn = 1'h0; w(6);
    chk(rdy, !busy);
    w(20); wrn = 1'h1;
    for (int i = 0; i < 400 && rdy !== 1'h1; i++) w(1);
    chk(rdy, 1'h1);
  endtask : go
  // read one byte with output enable low, then release the bus
  task automatic rd(logic b2, logic b1, logic [7:0] e);
    bs2 = b2; bs1 = b1; oen = 1'h0; w(26);
    chk({doe, dout}, {1'h1, e});
    oen = 1'h1; w(5);
    chk(doe, 1'h0);
  endtask : rd
  task automatic wrap_up;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  // cycle ceiling against a hang
  always @(posedge clk) if (++cyc == 60000) begin
    errors++;
    wrap_up();
  end
  // main sequence
  initial begin
    w(10); rstn = 1'h1; w(2);
    chk({rdy, pm, fhi, lck}, {2'h2, FUSE_HIGH_RESET, LOCK_RESET});
    repeat (6) ld(2'h3, 1'h0, 8'h00);
    hv = 1'h1; w(20);
    chk({ef, pm}, 2'h2);
    hv = 1'h0; w(12);
    xa = 2'h0; w(12); hv = 1'h1; w(20);
    chk({ef, pm}, 2'h1);
    w(5000);
    ld(XA_CMD, 1'h0, CMD_WR_LOCK); ld(XA_DATA, 1'h0, 8'hFC); go(1'h1);
    ld(XA_CMD, 1'h0, CMD_WR_FUSE); ld(XA_DATA, 1'h0, 8'hE2); go(1'h1);
    ld(XA_CMD, 1'h0, CMD_RD_FUSE);
    rd(1'h0, 1'h1, 8'hFC);
    rd(1'h0, 1'h0, 8'hE2);
    rd(1'h1, 1'h1, FUSE_HIGH_RESET);
    rd(1'h1, 1'h0, FUSE_EXT_RESET);
    ld(XA_CMD, 1'h0, CMD_CHIP_ERASE); go(1'h1);
    chk({lck, flo}, {8'hFF, 8'hE2});
    $display("end entry, locks, fuses, erase");
    ah = lf[15:8];
    ld(XA_CMD, 1'h0, CMD_WR_FLASH); ld(XA_ADDR, 1'h1, ah);
    for (int i = 0; i < 128; i++) begin
      lf = nx(lf); pg[i] = lf[15:0];
      ld(XA_ADDR, 1'h0, {ah[0], 7'(i)});
      ld(XA_DATA, 1'h0, pg[i][7:0]); ld(XA_DATA, 1'h1, pg[i][15:8]);
      pl = 1'h1; w(26); pl = 1'h0;
    end
    go(1'h1);
    ld(XA_CMD, 1'h0, CMD_NOP); go(1'h0);
    ld(XA_CMD, 1'h0, CMD_RD_FLASH);
    for (int i = 1; i < 128; i += 9) begin
      ld(XA_ADDR, 1'h0, {ah[0], 7'(i)});
      rd(1'h0, 1'h0, pg[i][7:0]);
      rd(1'h0, 1'h1, pg[i][15:8]);
    end
    $display("end flash page");
    ld(XA_CMD, 1'h0, CMD_RD_SIG); ld(XA_ADDR, 1'h0, 8'h02);
    ld(2'h3, 1'h0, 8'h00); rd(1'h0, 1'h0, sig_of(2'h2));
    rd(1'h0, 1'h1, CAL_BYTE);
    ld(XA_CMD, 1'h0, CMD_WR_EE); ld(XA_ADDR, 1'h1, 8'h00);
    ld(XA_ADDR, 1'h0, 8'h0B); ld(XA_DATA, 1'h0, lf[23:16]);
    pl = 1'h1; w(26); pl = 1'h0; go(1'h1);
    ld(XA_CMD, 1'h0, CMD_RD_EE); rd(1'h0, 1'h0, lf[23:16]);
    ld(XA_ADDR, 1'h0, 8'h00); rd(1'h0, 1'h0, 8'hFF);
    $display("end signature and eeprom");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
